// >>> hw/mdsc_motor_ctrl.sv
// Motor drive signal control for main, transport and developer motors
`timescale 1ns/1ps
module mdsc_motor_ctrl (
   // Clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        resetn,
   // Wishbone slave
   input  wire logic [mdsc_pkg::ADDR_W-1:0] wb_adr_i,
   input  wire logic [31:0]                 wb_dat_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic                        wb_we_i,
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   output      logic [31:0]                 wb_dat_o,
   output      logic                        wb_ack_o,
   // Main motor driver
   output      logic                        main_run_n,
   output      logic                        main_brake_n,
   output      logic                        main_direction,
   output      logic                        main_speed_range,
   output      logic                        main_ref_clk,
   input  wire logic                        main_pll_fault,
   // Transport motor driver
   output      logic                        transport_run_n,
   output      logic                        transport_direction,
   output      logic                        transport_speed_range,
   output      logic                        transport_ref_clk,
   input  wire logic                        transport_pll_fault,
   // Developer motor driver and clutch
   output      logic                        developer_run_n,
   output      logic                        developer_direction,
   output      logic                        developer_ref_clk,
   input  wire logic                        developer_pll_fault,
   input  wire logic                        revolver_rotating,
   output      logic                        color_clutch_on
);
   import mdsc_pkg::*;

   // ======================================================================
   // State
   mdsc_ctrl_t        ctrl_q;
   logic [DIV_W-1:0]  div_q [MOTORS];
   logic [SET_W-1:0]  settle_q;
   logic [MOTORS-1:0] fault_q;
   logic              reduced_q;
   logic              rev_s1_q, rev_s2_q;
   logic              ack_q;
   logic [31:0]       rd_q;
   logic              main_run_n_q, main_brake_n_q, main_dir_q;
   logic              main_range_q, trans_run_n_q, trans_dir_q;
   logic              trans_range_q, dev_run_n_q, dev_dir_q, clutch_q;

   // ======================================================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   // Reduced rates are 1/2, 1/3 or 1/4; a zero select means half
   function automatic logic [2:0] factor(input logic [1:0] sel);
      return (sel == SEL_NONE) ? FAC_HALF : ({1'b0, sel} + FAC_NORM);
   endfunction

   // ======================================================================
   // Bus decode
   wire         req      = wb_cyc_i & wb_stb_i & ~ack_q;
   wire         wr_en    = req & wb_we_i;
   wire         wr_ctrl  = wr_en & (wb_adr_i == OFS_CTRL);
   wire         wr_set   = wr_en & (wb_adr_i == OFS_SETTLE);
   wire         wr_stat  = wr_en & (wb_adr_i == OFS_STATUS);
   wire         wr_xfer  = wr_en & (wb_adr_i == OFS_XFER);
   wire         xfer_first_wr = wr_xfer & wb_sel_i[0] & wb_dat_i[XF_FIRST];
   wire [31:0]  ctrl_w   = {{(32-CTRL_W){1'b0}}, ctrl_q};
   wire [31:0]  ctrl_nx  = merge(ctrl_w, wb_dat_i, wb_sel_i);
   wire [31:0]  set_nx   = merge({16'h0000, settle_q}, wb_dat_i, wb_sel_i);
   wire [MOTORS-1:0] clr = wr_stat & wb_sel_i[0]
                         ? wb_dat_i[ST_FAULT_LSB +: MOTORS] : '0;

   wire [MOTORS-1:0] pll_sync;
   wire [MOTORS-1:0] fault_evt;
   wire [MOTORS-1:0] ref_w;

   wire [31:0] status_w = {23'h000000, clutch_q, rev_s2_q, reduced_q,
                           fault_q, pll_sync};

   wire [31:0] rd_w =
        (wb_adr_i == OFS_CTRL)      ? ctrl_w :
        (wb_adr_i == OFS_MAIN_DIV)  ? {16'h0000, div_q[M_MAIN]} :
        (wb_adr_i == OFS_TRANS_DIV) ? {16'h0000, div_q[M_TRANS]} :
        (wb_adr_i == OFS_DEV_DIV)   ? {16'h0000, div_q[M_DEV]} :
        (wb_adr_i == OFS_SETTLE)    ? {16'h0000, settle_q} :
        (wb_adr_i == OFS_STATUS)    ? status_w : 32'h00000000;

   // ======================================================================
   // Speed selection
   wire         trans_slow = ctrl_q.thick_mode & ctrl_q.color_mode;
   wire [2:0]   fac_main   = reduced_q ? factor(ctrl_q.main_div_sel)
                                       : FAC_NORM;          // [RULE7]
   wire [2:0]   fac_trans  = trans_slow ? factor(ctrl_q.trans_div_sel)
                                        : FAC_NORM;         // [RULE14]
   wire [MOTORS-1:0] run_w = {ctrl_q.dev_run, ctrl_q.trans_run,
                              ctrl_q.main_run};
   wire [MOTORS-1:0] pin_w = {developer_pll_fault, transport_pll_fault,
                              main_pll_fault};
   wire [CNT_W-1:0] half_w [MOTORS];

   assign half_w[M_MAIN]  = CNT_W'(div_q[M_MAIN]) * CNT_W'(fac_main);
   assign half_w[M_TRANS] = CNT_W'(div_q[M_TRANS]) * CNT_W'(fac_trans);
   assign half_w[M_DEV]   = CNT_W'(div_q[M_DEV]);

   // ======================================================================
   // Channels
   generate
      for (genvar i = 0; i < MOTORS; i++) begin : g_chan
         mdsc_motor_chan #(
            .CNT_W (CNT_W),
            .SET_W (SET_W)
         ) u_chan (
            .sys_clk       (sys_clk),
            .resetn        (resetn),
            .run           (run_w[i]),
            .half_period   (half_w[i]),
            .settle        (settle_q),
            .pll_fault_pin (pin_w[i]),
            .ref_clk       (ref_w[i]),
            .pll_fault     (pll_sync[i]),
            .fault_evt     (fault_evt[i])
         );
      end
   endgenerate

   // ======================================================================
   // Bus slave: one wait state, ack drops in the cycle after
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         rd_q  <= 32'h00000000;
      end else begin
         ack_q <= req;
         rd_q  <= req ? rd_w : rd_q;
      end
   end

   // ======================================================================
   // Software registers
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrl_q   <= mdsc_ctrl_t'(RST_CTRL);
         settle_q <= RST_SETTLE;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= mdsc_ctrl_t'(ctrl_nx[CTRL_W-1:0]);
         end
         if (wr_set) begin
            settle_q <= set_nx[SET_W-1:0];
         end
      end
   end

   generate
      for (genvar i = 0; i < MOTORS; i++) begin : g_div
         wire [ADDR_W-1:0] ofs = OFS_MAIN_DIV + ADDR_W'(4 * i);
         wire [31:0]       nx  = merge({16'h0000, div_q[i]}, wb_dat_i,
                                       wb_sel_i);
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               div_q[i] <= RST_DIV;
            end else if (wr_en && wb_adr_i == ofs) begin
               div_q[i] <= nx[DIV_W-1:0];                   // [RULE21]
            end
         end
      end
   endgenerate

   // Sticky faults: a new event beats a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         fault_q <= '0;
      end else begin
         fault_q <= (fault_q & ~clr) | fault_evt;           // [RULE20]
      end
   end

   // Main slowdown is armed by the first-transfer-done strobe only,
   // so it starts after the first transfer and holds until thick mode drops
   always_ff @(posedge sys_clk) begin
      if (!resetn || !ctrl_q.thick_mode) begin
         reduced_q <= 1'b0;
      end else if (xfer_first_wr) begin
         reduced_q <= 1'b1;                                 // [RULE8]
      end
   end

   // ======================================================================
   // Revolver pin synchroniser and clutch
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rev_s1_q <= 1'b0;
         rev_s2_q <= 1'b0;
         clutch_q <= 1'b0;
      end else begin
         rev_s1_q <= revolver_rotating;
         rev_s2_q <= rev_s1_q;
         clutch_q <= ctrl_q.dev_run & ~rev_s2_q;            // [RULE19]
      end
   end

   // ======================================================================
   // Driver output flops; reset leaves every motor stopped, brake off
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         main_run_n_q   <= 1'b1;
         main_brake_n_q <= 1'b1;
         main_dir_q     <= DIR_FWD;
         main_range_q   <= 1'b0;
         trans_run_n_q  <= 1'b1;
         trans_dir_q    <= DIR_FWD;
         trans_range_q  <= 1'b0;
         dev_run_n_q    <= 1'b1;
         dev_dir_q      <= DIR_FWD;
      end else begin
         main_run_n_q   <= ~ctrl_q.main_run;                // [RULE1]
         main_brake_n_q <= ~ctrl_q.main_brake;              // [RULE2]
         main_dir_q     <= ctrl_q.main_fwd;                 // [RULE3]
         main_range_q   <= ctrl_q.main_hi_range;            // [RULE4]
         trans_run_n_q  <= ~ctrl_q.trans_run;               // [RULE9]
         trans_dir_q    <= DIR_FWD;                         // [RULE10]
         trans_range_q  <= ctrl_q.trans_hi_range;           // [RULE11]
         dev_run_n_q    <= ~ctrl_q.dev_run;                 // [RULE15]
         dev_dir_q      <= DIR_FWD;                         // [RULE16]
      end
   end

   assign wb_dat_o              = rd_q;
   assign wb_ack_o              = ack_q;
   assign main_run_n            = main_run_n_q;
   assign main_brake_n          = main_brake_n_q;
   assign main_direction        = main_dir_q;
   assign main_speed_range      = main_range_q;
   assign main_ref_clk          = ref_w[M_MAIN];            // [RULE5]
   assign transport_run_n       = trans_run_n_q;
   assign transport_direction   = trans_dir_q;
   assign transport_speed_range = trans_range_q;
   assign transport_ref_clk     = ref_w[M_TRANS];           // [RULE12]
   assign developer_run_n       = dev_run_n_q;
   assign developer_direction   = dev_dir_q;
   assign developer_ref_clk     = ref_w[M_DEV];             // [RULE17]
   assign color_clutch_on       = clutch_q;

   // ======================================================================
   // Assertions
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   a_main_run_cmd: assert property (                     // [RULE1]
      $rose(ctrl_q.main_run) |=> !main_run_n ##1 $stable(ctrl_q.main_run)
      || !main_run_n)
      else $error("main run line not low after run command");

   a_main_stop_cmd: assert property (                    // [RULE1]
      !ctrl_q.main_run |=> main_run_n)
      else $error("main run line not high after stop command");

   a_main_brake_cmd: assert property (                   // [RULE2]
      ctrl_q.main_brake ##1 ctrl_q.main_brake |-> !main_brake_n)
      else $error("main brake line not low while braking");

   a_brake_release: assert property (                    // [RULE2]
      !ctrl_q.main_brake |=> main_brake_n)
      else $error("main brake line not high in normal running");

   a_main_dir_follow: assert property (                  // [RULE3]
      $changed(ctrl_q.main_fwd) |=> main_direction == $past(ctrl_q.main_fwd))
      else $error("main direction did not follow control");

   a_main_range_hold: assert property (                  // [RULE4]
      ctrl_q.main_hi_range [*2] |-> main_speed_range)
      else $error("main range line not high for high range");

   a_ref_idle_low: assert property (                     // [RULE5]
      !ctrl_q.main_run |=> !main_ref_clk)
      else $error("main reference clock runs while stopped");

   // Slowdown drops one cycle after thick mode does
   a_reduce_mode: assert property (                      // [RULE7]
      reduced_q |-> $past(ctrl_q.thick_mode) && fac_main >= FAC_HALF)
      else $error("main slowdown outside thick mode");

   a_reduce_timing: assert property (                    // [RULE8]
      $rose(reduced_q) |-> $past(xfer_first_wr))
      else $error("main slowdown not caused by first transfer");

   a_trans_run_cmd: assert property (                    // [RULE9]
      transport_run_n == !$past(ctrl_q.trans_run))
      else $error("transport run line does not follow control");

   a_fixed_forward: assert property (                    // [RULE10] [RULE16]
      ##1 transport_direction && developer_direction)
      else $error("transport or developer direction not forward");

   a_trans_range_cmd: assert property (                  // [RULE11]
      transport_speed_range == $past(ctrl_q.trans_hi_range))
      else $error("transport range line does not follow control");

   a_trans_ref_idle: assert property (                   // [RULE12]
      !ctrl_q.trans_run |=> !transport_ref_clk)
      else $error("transport reference clock runs while stopped");

   a_trans_slow: assert property (                       // [RULE14]
      trans_slow && ctrl_q.trans_div_sel == SEL_NONE
      |-> half_w[M_TRANS] == CNT_W'(div_q[M_TRANS]) * CNT_W'(2))
      else $error("transport slowdown factor wrong");

   a_dev_run_cmd: assert property (                      // [RULE15]
      developer_run_n == !$past(ctrl_q.dev_run))
      else $error("developer run line does not follow control");

   a_dev_ref_idle: assert property (                     // [RULE17]
      !ctrl_q.dev_run |=> !developer_ref_clk)
      else $error("developer reference clock runs while stopped");

   a_clutch_release: assert property (                   // [RULE19]
      rev_s2_q |=> !color_clutch_on)
      else $error("clutch engaged while revolver turns");

   a_fault_sticky: assert property (                     // [RULE20]
      fault_evt[M_MAIN] |=> fault_q[M_MAIN] [*2])
      else $error("main fault flag not held");

   a_bus_ack: assert property (
      req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus ack not a single cycle after request");

   c_main_reduced:   cover property ($rose(reduced_q));
   c_fault_raised:   cover property ($rose(fault_q[M_TRANS]));
   c_clutch_dropped: cover property (ctrl_q.dev_run && $fell(clutch_q));
   c_trans_slowed:   cover property (trans_slow && ctrl_q.trans_run);

endmodule // mdsc_motor_ctrl

// >>> hw/mdsc_pkg.sv
// Constants, register map and types for the motor drive signal control
// ==========================================================================
// Functional notes
// RULE1: Main run line low runs, high stops.
// RULE2: Main brake line low brakes, high normal.
// RULE3: Main direction low backward, high forward.
// RULE4: Main range select low slow, high fast.
// RULE5: Main reference clock frequency sets main speed.
// RULE6: Main driver PLL status high means out-of-control.
// RULE7: Thick/film mode slows main to half..quarter.
// RULE8: Main slowdown between first and second transfer; the code holds it from the first-transfer strobe until thick mode drops.
// RULE9: Transport run line low runs, high stops.
// RULE10: Transport direction high forward, never backward.
// RULE11: Transport range select high fast, low slow.
// RULE12: Transport reference clock sets transport speed.
// RULE13: Transport driver PLL status high means fault.
// RULE14: Color thick/film slows transport half/third/quarter.
// RULE15: Developer run line low runs, high stops.
// RULE16: Developer direction held high, forward only.
// RULE17: Developer reference clock sets developer speed.
// RULE18: Developer driver PLL status high means fault.
// RULE19: Color developer clutch released while revolver turns.
// RULE20: Flag fault when PLL unlocked past settle time.
// RULE21: Reference clocks from programmable system clock dividers.
package mdsc_pkg;

   // ======================================================================
   // Bus and widths
   localparam int ADDR_W   = 5;
   localparam int DIV_W    = 16;
   localparam int SET_W    = 16;
   localparam int CNT_W    = DIV_W + 3;
   localparam int MOTORS   = 3;

   // ======================================================================
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL      = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_MAIN_DIV  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_TRANS_DIV = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DEV_DIV   = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_SETTLE    = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS    = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_XFER      = 5'h18;

   // ======================================================================
   // Motor indices and field positions
   localparam int M_MAIN  = 0;
   localparam int M_TRANS = 1;
   localparam int M_DEV   = 2;

   localparam int ST_PLL_LSB   = 0;
   localparam int ST_FAULT_LSB = 3;
   localparam int ST_REDUCED   = 6;
   localparam int ST_REVOLVER  = 7;
   localparam int ST_CLUTCH    = 8;
   localparam int XF_FIRST     = 0;

   // ======================================================================
   // Reset values and fixed levels
   localparam logic [DIV_W-1:0] RST_DIV    = 16'h0064;
   localparam logic [SET_W-1:0] RST_SETTLE = 16'h2710;
   localparam logic             DIR_FWD    = 1'h1;
   localparam logic [2:0]       FAC_NORM   = 3'h1;
   localparam logic [2:0]       FAC_HALF   = 3'h2;
   localparam logic [1:0]       SEL_NONE   = 2'h0;

   // ======================================================================
   // Control register layout, bit 0 first from the bottom
   typedef struct packed {
      logic [1:0] main_div_sel;
      logic [1:0] trans_div_sel;
      logic       color_mode;
      logic       thick_mode;
      logic       dev_run;
      logic       trans_hi_range;
      logic       trans_run;
      logic       main_hi_range;
      logic       main_fwd;
      logic       main_brake;
      logic       main_run;
   } mdsc_ctrl_t;

   localparam int CTRL_W = $bits(mdsc_ctrl_t);
   localparam logic [CTRL_W-1:0] RST_CTRL = 13'h0004;

endpackage

// >>> hw/mdsc_motor_chan.sv
// One motor channel: reference clock divider and PLL fault watchdog
`timescale 1ns/1ps
module mdsc_motor_chan #(
   parameter int CNT_W = 19,
   parameter int SET_W = 16
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // Control
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] half_period,
   input  wire logic [SET_W-1:0] settle,
   // Driver side
   input  wire logic             pll_fault_pin,
   output      logic             ref_clk,
   output      logic             pll_fault,
   output      logic             fault_evt
);
   logic             s1_q, s2_q;
   logic [CNT_W-1:0] div_q;
   logic [SET_W-1:0] set_q;
   logic             done_q, evt_q, ref_q;

   wire [CNT_W:0] div_nx   = {1'b0, div_q} + {{CNT_W{1'b0}}, 1'b1};
   wire           tick     = div_nx >= {1'b0, half_period};
   wire           unlocked = run & s2_q;
   wire           expire   = unlocked & ~done_q & (set_q == settle);

   // ======================================================================
   // Pin synchroniser
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= pll_fault_pin;
         s2_q <= s1_q;
      end
   end

   // ======================================================================
   // Divider: clock stays low while stopped so the driver sees no pulses
   always_ff @(posedge sys_clk) begin
      if (!resetn || !run) begin
         div_q <= '0;
         ref_q <= 1'b0;
      end else if (tick) begin
         div_q <= '0;
         ref_q <= ~ref_q;                                  // [RULE21]
      end else begin
         div_q <= div_nx[CNT_W-1:0];
      end
   end

   // ======================================================================
   // Watchdog restarts whenever lock returns or the motor stops
   always_ff @(posedge sys_clk) begin
      if (!resetn || !unlocked) begin                      // [RULE6]
         set_q  <= '0;
         done_q <= 1'b0;
      end else if (expire) begin
         done_q <= 1'b1;
      end else if (!done_q) begin
         set_q <= set_q + {{(SET_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         evt_q <= 1'b0;
      end else begin
         evt_q <= expire;                                  // [RULE20]
      end
   end

   assign ref_clk   = ref_q;
   assign pll_fault = s2_q;
   assign fault_evt = evt_q;

endmodule // mdsc_motor_chan

// >>> tb/mdsc_drv_model.sv
// Behavioural brushless motor driver that reports its PLL lock status
`timescale 1ns/1ps
module mdsc_drv_model (
   // Driver inputs
   input  wire logic run_n,
   input  wire logic ref_clk,
   input  wire logic bad,
   // Status back to the controller
   output      logic pll_fault
);
   // ======================================================================
   // Lock tracking
   int locks = 0;
   // Needs two reference edges to lock; a stopped motor reads normal unless bad is high
   always @(posedge ref_clk or posedge run_n) begin
      if (run_n)
         locks <= 0;
      else if (locks < 2)
         locks <= locks + 1;
   end
   // High while out of control, low while locked
   assign pll_fault = bad | (!run_n && locks < 2);
endmodule // mdsc_drv_model

// >>> tb/testbench.sv
// Self-checking bench for the motor drive signal control block
`timescale 1ns/1ps
module testbench;
   import mdsc_pkg::*;
   logic sys_clk, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [ADDR_W-1:0] wb_adr_i;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [3:0] wb_sel_i;
   logic main_run_n, main_brake_n, main_direction, main_speed_range;
   logic main_ref_clk, main_pll_fault, transport_run_n, transport_ref_clk;
   logic transport_direction, transport_speed_range, transport_pll_fault;
   logic developer_run_n, developer_direction, developer_ref_clk;
   logic developer_pll_fault, revolver_rotating, color_clutch_on;
   logic [2:0] bad, refs;
   logic [12:0] c;
   int err_total = 0, num_checks = 0, cycles = 0, n;
   // ======================================================================
   // Design and far-side drivers
   mdsc_motor_ctrl dut_u (.sys_clk, .resetn, .wb_adr_i, .wb_dat_i,
      .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
      .main_run_n, .main_brake_n, .main_direction, .main_speed_range,
      .main_ref_clk, .main_pll_fault, .transport_run_n, .transport_ref_clk,
      .transport_direction, .transport_speed_range, .transport_pll_fault,
      .developer_run_n, .developer_direction, .developer_ref_clk,
      .developer_pll_fault, .revolver_rotating, .color_clutch_on);
   mdsc_drv_model m0_u (.run_n(main_run_n), .ref_clk(main_ref_clk),
      .bad(bad[0]), .pll_fault(main_pll_fault));
   mdsc_drv_model m1_u (.run_n(transport_run_n), .ref_clk(transport_ref_clk),
      .bad(bad[1]), .pll_fault(transport_pll_fault));
   mdsc_drv_model m2_u (.run_n(developer_run_n), .ref_clk(developer_ref_clk),
      .bad(bad[2]), .pll_fault(developer_pll_fault));
   assign refs = {developer_ref_clk, transport_ref_clk, main_ref_clk};
   // ======================================================================
   // Expectations
   function automatic logic [31:0] fac(input int s);
      return (s < 2) ? 32'h2 : s + 1;
   endfunction
   function automatic logic [9:0] exp_pins(input logic [12:0] v,
                                           input logic r);
      return {~v[0], ~v[1], v[2], v[3], ~v[4], 1'h1, v[5], ~v[6], 1'h1,
              v[6] & ~r};
   endfunction
   // ======================================================================
   // Bus, checks and closing
   task automatic chk(input string nm, input logic [31:0] e, g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
      @(posedge sys_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      // Hold the request until ack is sampled high at an edge
      do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask
   task automatic meas(input int m);
      logic p;
      @(posedge sys_clk);
      p = refs[m];
      do @(posedge sys_clk); while (refs[m] === p);
      p = refs[m];
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (refs[m] === p);
   endtask
   task automatic conclude();
      if (err_total == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end
   // Cut a hang short well past the expected run length
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         conclude();
      end
   end
   // ======================================================================
   // Scenarios
   initial begin
      {resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      bad = 3'h0;
      revolver_rotating = 1'h0;
      void'($urandom(32'hCC8EEFCE));
      repeat (20) @(posedge sys_clk);
      resetn <= 1'h1;
      chk("pins_rst", exp_pins(13'h0004, 1'h0), main_run_n ? {main_run_n,
         main_brake_n, main_direction, main_speed_range, transport_run_n,
         transport_direction, transport_speed_range, developer_run_n,
         developer_direction, color_clutch_on} : 10'h0);
      wb(1'h1, 5'h1C, 32'hFFFFFFFF);
      foreach (c[i]) if (i < 6) begin
         wb(1'h0, (i == 5) ? 5'h1C : 5'(4 * i), 32'h0);
         chk("reg_rst", (i == 0) ? 32'h4 : (i == 4) ? 32'h2710 :
             (i == 5) ? 32'h0 : 32'h64, q);
      end
      // Random pin commands with the revolver moving at random
      repeat (16) begin
         c = 13'($urandom);
         revolver_rotating <= 1'($urandom);
         wb(1'h1, 5'h00, {19'h0, c});
         repeat (4) @(posedge sys_clk);
         chk("pins", exp_pins(c, revolver_rotating), {main_run_n,
            main_brake_n, main_direction,
            main_speed_range, transport_run_n,
            transport_direction, transport_speed_range,
            developer_run_n, developer_direction,
            color_clutch_on});
      end
      revolver_rotating <= 1'h0;
      wb(1'h1, 5'h04, 32'h3);
      wb(1'h1, 5'h08, 32'h3);
      wb(1'h1, 5'h0C, 32'h5);
      wb(1'h1, 5'h00, 32'h1D5);
      meas(0);
      chk("main_half_pre", 32'h3, n);
      meas(2);
      chk("dev_half", 32'h5, n);
      wb(1'h1, 5'h18, 32'h1);
      for (int s = 0; s < 4; s++) begin
         wb(1'h1, 5'h00, 32'h1D5 | (s << 9) | (s << 11));
         meas(0);
         chk("main_half", 3 * fac(s), n);
         meas(1);
         chk("trans_half", 3 * fac(s), n);
      end
      wb(1'h1, 5'h00, 32'h055);
      meas(0);
      chk("main_half_norm", 32'h3, n);
      // All three drivers out of control past a short settle time
      wb(1'h1, 5'h10, 32'h4);
      bad <= 3'h7;
      repeat (20) @(posedge sys_clk);
      wb(1'h0, 5'h14, 32'h0);
      chk("fault_set", 32'h3F, q & 32'h3F);
      bad <= 3'h0;
      repeat (6) @(posedge sys_clk);
      wb(1'h1, 5'h14, 32'h38);
      wb(1'h0, 5'h14, 32'h0);
      chk("fault_clr", 32'h0, q & 32'h3F);
      conclude();
   end
endmodule // testbench
